// ===== src/eptc_pkg.sv
/*
 * Shared constants, types and decode helpers for the energy threshold
 * configuration block.
 * Assumes a 250 MHz clock and a 32-bit AHB-Lite register bus.
 */
package eptc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_START       = 8'h30;
    localparam logic [7:0]  IDX_THR_HI      = 8'h31;
    localparam logic [7:0]  IDX_THR_LO      = 8'h32;
    localparam logic [7:0]  IDX_CHK_EXP     = 8'h3e;
    localparam logic [7:0]  IDX_STATUS      = 8'h3f;
    localparam logic [7:0]  IDX_ENERGY0     = 8'h70;

    // ------------------------------------------------------------
    // Reset values and start codes
    // ------------------------------------------------------------
    localparam logic [15:0] START_RST       = 16'h6886;
    localparam logic [15:0] CODE_CAL        = 16'h5678;
    localparam logic [15:0] CODE_OPER       = 16'h8765;
    localparam logic [15:0] THR_HI_RST      = 16'h0861;
    localparam logic [15:0] THR_LO_RST      = 16'hc468;
    localparam logic [15:0] CHK_EXP_RST     = 16'h0000;

    // ------------------------------------------------------------
    // Status fields, bus codes, counts and timing
    // ------------------------------------------------------------
    localparam int          ST_CSERR_BIT    = 0;
    localparam int          ST_HALT_BIT     = 1;
    localparam int          ST_MODE_LSB     = 2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    localparam logic [6:0]  CENTI_PER_CF    = 7'h64;
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          CF_PULSE_NS     = 1000;
    localparam int          CF_PULSE_CYC    = (CF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_POWERUP = 2'b00,
        MODE_CAL     = 2'b01,
        MODE_OPER    = 2'b10,
        MODE_BAD     = 2'b11
    } eptc_mode_t;

    function automatic eptc_mode_t eptc_decode(input logic [15:0] code);
        if (code == START_RST)
            return MODE_POWERUP;
        else if (code == CODE_CAL)
            return MODE_CAL;
        else if (code == CODE_OPER)
            return MODE_OPER;
        else
            return MODE_BAD;
    endfunction

    function automatic logic [15:0] eptc_group_sum(input logic [15:0] hi, input logic [15:0] lo);
        return 16'(hi + lo);
    endfunction

endpackage

// ===== src/eptc_acc_if.sv
/*
 * Carrier between the register bank, the per-channel accumulators and
 * the pulse shapers.
 * Assumes all three ends run on the same clock.
 */
`timescale 1ns/100ps
interface eptc_acc_if;
    logic [31:0] thresh;
    logic        run;
    logic        clear;
    logic        inc;
    logic        cf_evt;
    logic [15:0] energy;
    logic        cf_level;

    modport top (output thresh, output run, output clear,
                 input inc, input energy, input cf_level);
    modport acc (input thresh, input run, input clear,
                 output inc, output cf_evt, output energy);
    modport pul (input cf_evt, input clear, output cf_level);
endinterface

// ===== src/eptc_pulse.sv
/*
 * Stretches one CF event into a fixed-width pulse.
 * Assumes events arrive as one-cycle strobes on the same clock.
 */
`timescale 1ns/100ps
module eptc_pulse
    import eptc_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Channel link
    eptc_acc_if.pul   p
);
    localparam int CW = $clog2(CF_PULSE_CYC + 1);

    typedef enum logic {PUL_IDLE = 1'b0, PUL_HIGH = 1'b1} eptc_pul_st_t;
    typedef struct packed {
        eptc_pul_st_t   st;
        logic [CW-1:0]  cnt;
        logic           level;
    } eptc_pul_t;

    eptc_pul_t s_r;
    eptc_pul_t s_nxt;

    // Events during a pulse are dropped: CF rate is far below the width
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            PUL_IDLE: begin
                if (p.cf_evt) begin
                    s_nxt.st  = PUL_HIGH;
                    s_nxt.cnt = CW'(CF_PULSE_CYC - 1);
                end
            end
            PUL_HIGH: begin
                if (s_r.cnt == '0)
                    s_nxt.st = PUL_IDLE;
                else
                    s_nxt.cnt = s_r.cnt - 1'b1;
            end
        endcase
        if (p.clear)
            s_nxt.st = PUL_IDLE;
        s_nxt.level = (s_nxt.st == PUL_HIGH);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign p.cf_level = s_r.level;

    a_pulse_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        p.cf_evt && !s_r.level && !p.clear |=> s_r.level [*8])
        else $error("CF event did not start a pulse");
endmodule

// ===== src/eptc_accum.sv
/*
 * Per-channel energy accumulator: compares against the threshold, keeps
 * the remainder, counts hundredths and flags each whole CF.
 * Assumes energy deltas come from logic on the same clock.
 */
`timescale 1ns/100ps
module eptc_accum
    import eptc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Energy datapath
    input  wire logic        energy_valid,
    input  wire logic [15:0] energy_delta,
    // Channel link
    eptc_acc_if.acc          a
);
    typedef struct packed {
        logic [32:0] acc;
        logic [6:0]  centi;
        logic [15:0] energy;
        logic        inc;
        logic        cf_evt;
    } eptc_acc_t;

    eptc_acc_t   s_r;
    eptc_acc_t   s_nxt;
    logic [33:0] sum;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.inc    = 1'b0;
        s_nxt.cf_evt = 1'b0;
        sum          = {1'b0, s_r.acc};
        if (energy_valid && a.run)
            sum = sum + {18'h0, energy_delta};
        // Halted metering neither adds nor increments
        if (a.run && sum > {2'b0, a.thresh}) begin
            s_nxt.inc    = 1'b1;
            s_nxt.energy = s_r.energy + 16'h1;
            s_nxt.acc    = 33'(sum - {2'b0, a.thresh});
            if (s_r.centi == CENTI_PER_CF - 7'h1) begin
                s_nxt.centi  = '0;
                s_nxt.cf_evt = 1'b1;
            end else begin
                s_nxt.centi = s_r.centi + 7'h1;
            end
        end else begin
            s_nxt.acc = 33'(sum);
        end
        if (a.clear)
            s_nxt = '0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign a.inc    = s_r.inc;
    assign a.cf_evt = s_r.cf_evt;
    assign a.energy = s_r.energy;

    a_inc_on_exceed: assert property (@(posedge hclk) disable iff (!hresetn)
        a.run && !a.clear && sum > {2'b0, a.thresh} |=> s_r.inc && a.energy == $past(a.energy) + 16'h1)
        else $error("Threshold exceeded without increment");
    a_keep_remainder: assert property (@(posedge hclk) disable iff (!hresetn)
        a.run && !a.clear && sum > {2'b0, a.thresh} |=> {1'b0, s_r.acc} == $past(sum) - {2'b0, $past(a.thresh)})
        else $error("Remainder lost after increment");
    a_cf_per_hundred: assert property (@(posedge hclk) disable iff (!hresetn)
        s_nxt.inc && !a.clear && s_r.centi == 7'h63 |=> s_r.cf_evt)
        else $error("No CF event after one hundred increments");
endmodule

// ===== src/eptc_top.sv
/*
 * Configuration start register and energy threshold bank with an
 * AHB-Lite slave, checksum supervision and per-channel CF outputs.
 * Assumes a single AHB-Lite master on hclk and energy deltas from
 * logic in the same clock domain.
 */
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps

// Functional notes
// - The 32-bit energy threshold is the high register above the low register.
// - Energy beyond the threshold adds one hundredth of a CF to the channel energy.
// - Each whole CF accumulated on a channel gives a pulse on that channel output, except one that comes while a pulse is high or with a calibration clear.
// - The start register is a 16-bit read-write code that resets to the power-up code.
// - Power-up and calibration codes block checksum errors; writing calibration resets the group.
// - In the operation code a checksum mismatch raises interrupt and warning and halts metering.
// - Any other start code forces a checksum error and stops the system.
module eptc_top
    import eptc_pkg::*;
#(
    parameter int N_CH   = 3,
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [ADDR_W-1:0]     haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output      logic [31:0]           hrdata,
    output      logic                  hreadyout,
    output      logic                  hresp,
    // Energy datapath
    input  wire logic [N_CH-1:0]       energy_valid,
    input  wire logic [N_CH-1:0][15:0] energy_delta,
    // Metering outputs
    output      logic [N_CH-1:0]       energy_pulse_output,
    output      logic                  irq,
    output      logic                  warn
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (N_CH < 1 || N_CH > 16)
        $error("N_CH must lie in 1..16");
    if (ADDR_W < 10)
        $error("ADDR_W must be at least 10");

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] start;
        logic [15:0] thr_hi;
        logic [15:0] thr_lo;
        logic [15:0] chk_exp;
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic [31:0] rdata;
        logic        cs_err;
        logic        clr;
        logic        ready;
    } eptc_top_t;

    eptc_top_t              s_r;
    eptc_top_t              s_nxt;
    logic                   addr_ok;
    logic [7:0]             idx;
    logic [7:0]             eidx;
    eptc_mode_t             mode;
    logic                   mism;
    logic [N_CH-1:0][15:0]  energy_w;
    logic [N_CH-1:0]        cf_w;

    assign idx     = haddr[9:2];
    assign eidx    = idx - IDX_ENERGY0;
    assign addr_ok = hsel && htrans[1] && hready;

    // ------------------------------------------------------------
    // Register bank and bus slave
    // ------------------------------------------------------------
    // Writes land in the data phase; reads are sampled from the
    // already-updated values so a read right after a write sees it.
    always_comb begin
        s_nxt         = s_r;
        s_nxt.clr     = 1'b0;
        s_nxt.wr_pend = 1'b0;
        s_nxt.ready   = 1'b1;
        if (s_r.wr_pend) begin
            case (s_r.wr_idx)
                IDX_START: begin
                    s_nxt.start = hwdata[15:0];
                    if (hwdata[15:0] == CODE_CAL) begin
                        s_nxt.thr_hi  = THR_HI_RST;
                        s_nxt.thr_lo  = THR_LO_RST;
                        s_nxt.chk_exp = CHK_EXP_RST;
                        s_nxt.clr     = 1'b1;
                    end
                end
                IDX_THR_HI:  s_nxt.thr_hi  = hwdata[15:0];
                IDX_THR_LO:  s_nxt.thr_lo  = hwdata[15:0];
                IDX_CHK_EXP: s_nxt.chk_exp = hwdata[15:0];
                default: ;
            endcase
        end
        mode = eptc_decode(s_nxt.start);
        mism = eptc_group_sum(s_nxt.thr_hi, s_nxt.thr_lo) != s_nxt.chk_exp;
        s_nxt.cs_err = (mode == MODE_OPER && mism)
                     || mode == MODE_BAD;
        if (addr_ok) begin
            // Only whole-word writes are taken; narrower ones are dropped
            s_nxt.wr_pend = hwrite && hsize == HSIZE_WORD;
            s_nxt.wr_idx  = idx;
            s_nxt.rdata   = 32'h0;
            if (!hwrite) begin
                case (idx)
                    IDX_START:   s_nxt.rdata = {16'h0, s_nxt.start};
                    IDX_THR_HI:  s_nxt.rdata = {16'h0, s_nxt.thr_hi};
                    IDX_THR_LO:  s_nxt.rdata = {16'h0, s_nxt.thr_lo};
                    IDX_CHK_EXP: s_nxt.rdata = {16'h0, s_nxt.chk_exp};
                    IDX_STATUS: begin
                        s_nxt.rdata[ST_CSERR_BIT]               = s_nxt.cs_err;
                        s_nxt.rdata[ST_HALT_BIT]                = s_nxt.cs_err;
                        s_nxt.rdata[ST_MODE_LSB +: 2]           = mode;
                    end
                    default: begin
                        if (eidx < 8'(N_CH))
                            s_nxt.rdata = {16'h0, energy_w[eidx[3:0]]};
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r         <= '0;
            s_r.start   <= START_RST;
            s_r.thr_hi  <= THR_HI_RST;
            s_r.thr_lo  <= THR_LO_RST;
            s_r.chk_exp <= CHK_EXP_RST;
            s_r.ready   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata    = s_r.rdata;
    assign hreadyout = s_r.ready;
    assign hresp     = 1'b0;
    assign irq       = s_r.cs_err;
    assign warn      = s_r.cs_err;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    // Threshold is taken as programmed; multiples of four are left to
    // software, the datapath works with any value.
    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        eptc_acc_if ch_if ();

        assign ch_if.thresh = {s_r.thr_hi, s_r.thr_lo};
        assign ch_if.run    = !s_r.cs_err;
        assign ch_if.clear  = s_r.clr;
        assign energy_w[g]  = ch_if.energy;
        assign cf_w[g]      = ch_if.cf_level;

        eptc_accum u_accum (
            .hclk         (hclk),
            .hresetn      (hresetn),
            .energy_valid (energy_valid[g]),
            .energy_delta (energy_delta[g]),
            .a            (ch_if.acc)
        );

        eptc_pulse u_pulse (
            .hclk    (hclk),
            .hresetn (hresetn),
            .p       (ch_if.pul)
        );
    end

    assign energy_pulse_output = cf_w;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic wr_seen_r;
    logic wr_start;

    assign wr_start = s_r.wr_pend && s_r.wr_idx == IDX_START;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wr_seen_r <= 1'b0;
        else if (wr_start)
            wr_seen_r <= 1'b1;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_start_reset: assert property (!wr_seen_r |-> s_r.start == 16'h6886)
        else $error("Start code left power-up value without a write");
    a_start_write: assert property (wr_start |=> s_r.start == $past(hwdata[15:0]))
        else $error("Start code write not stored");
    a_thr_concat: assert property (s_r.wr_pend && s_r.wr_idx == IDX_THR_HI
        |=> g_ch[0].ch_if.thresh[31:16] == $past(hwdata[15:0]))
        else $error("Threshold high word not in upper half");
    a_thr_low: assert property (s_r.wr_pend && s_r.wr_idx == IDX_THR_LO
        |=> g_ch[0].ch_if.thresh[15:0] == $past(hwdata[15:0]))
        else $error("Threshold low word not in lower half");
    a_cal_reset: assert property (wr_start && hwdata[15:0] == 16'h5678
        |=> s_r.thr_hi == 16'h0861 && s_r.thr_lo == 16'hc468 && s_r.clr ##1 !s_r.clr)
        else $error("Calibration code did not reset the group");
    a_cal_quiet: assert property (eptc_decode(s_r.start) inside {MODE_POWERUP, MODE_CAL}
        |-> !irq && !warn)
        else $error("Checksum error raised in power-up or calibration");
    a_oper_check: assert property (eptc_decode(s_r.start) == MODE_OPER
        && s_r.thr_hi + s_r.thr_lo != s_r.chk_exp |-> irq && warn && !g_ch[0].ch_if.run)
        else $error("Checksum mismatch not flagged in operation");
    a_oper_clean: assert property (eptc_decode(s_r.start) == MODE_OPER
        && 16'(s_r.thr_hi + s_r.thr_lo) == s_r.chk_exp |-> !irq)
        else $error("Checksum error without mismatch");
    a_bad_code: assert property (eptc_decode(s_r.start) == MODE_BAD
        |-> irq && warn && !g_ch[0].ch_if.run)
        else $error("Illegal start code did not stop metering");
    a_halt_quiet: assert property (irq ##1 irq |-> !g_ch[0].ch_if.inc)
        else $error("Increment while metering halted");
    a_read_data: assert property (addr_ok && !hwrite && idx == IDX_THR_LO && !s_r.wr_pend
        |=> hrdata == {16'h0, s_r.thr_lo})
        else $error("Read data of threshold low wrong");

    c_cal_write: cover property (wr_start && hwdata[15:0] == 16'h5678);
    c_oper_err:  cover property (eptc_decode(s_r.start) == MODE_OPER ##1 irq);
    c_cf_pulse:  cover property ($rose(energy_pulse_output[0]));
    c_status_rd: cover property (addr_ok && !hwrite && idx == IDX_STATUS);
endmodule

// ===== verif/tb_energy_pulse_threshold_config.sv
/*
 * Self-checking bench for the energy threshold configuration block:
 * register reset values and read-write, start-code modes, checksum
 * supervision, threshold compare, remainder keeping and CF pulses.
 * Assumes the block answers AHB-Lite with zero wait states and that
 * hready is the slave's own hreadyout.
 */
`timescale 1ns/100ps
module tb_energy_pulse_threshold_config
    import eptc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic [11:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic [2:0]       energy_valid;
    logic [2:0][15:0] energy_delta;
    logic [2:0]       energy_pulse_output;
    logic             irq;
    logic             warn;
    int               num_errors;
    int               samples_checked;
    logic [31:0]      seed;
    logic [31:0]      thr;
    logic [32:0]      acc [3];
    logic [15:0]      cnt [3];
    int               pulses [3];
    logic [2:0]       pulse_q;
    logic             model_run;
    logic [31:0]      rd;
    logic [31:0]      v;
    logic [31:0]      w;
    logic [15:0]      sum;
    logic [15:0]      bad;
    logic [2:0][15:0] dd;

    eptc_top i_dut (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .hsel                (hsel),
        .haddr               (haddr),
        .htrans              (htrans),
        .hwrite              (hwrite),
        .hsize               (hsize),
        .hwdata              (hwdata),
        .hready              (hreadyout),
        .hrdata              (hrdata),
        .hreadyout           (hreadyout),
        .hresp               (hresp),
        .energy_valid        (energy_valid),
        .energy_delta        (energy_delta),
        .energy_pulse_output (energy_pulse_output),
        .irq                 (irq),
        .warn                (warn)
    );

    always #2 hclk = ~hclk;

    // Rising edges only, so a stretched pulse counts once
    always @(posedge hclk) begin
        pulse_q <= energy_pulse_output;
        for (int g = 0; g < 3; g++)
            if (energy_pulse_output[g] === 1'b1 && pulse_q[g] !== 1'b1) pulses[g]++;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {2'b00, idx, 2'b00};
        hwrite <= wr_en;
        hsize  <= HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        xfer(1'b1, idx, wd);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask

    task automatic flags(input logic exp);
        // Flags move on the edge that ends a write; look one edge later
        @(posedge hclk);
        check({31'h0, irq}, {31'h0, exp});
        check({31'h0, warn}, {31'h0, exp});
    endtask

    // Reference accumulator: strict compare, remainder carried over
    task automatic sample(input logic [2:0] vm, input logic [2:0][15:0] d);
        energy_valid <= vm;
        energy_delta <= d;
        for (int g = 0; g < 3; g++) begin
            if (vm[g] && model_run) begin
                if (acc[g] + 33'(d[g]) > 33'(thr)) begin
                    cnt[g]++;
                    acc[g] = acc[g] + 33'(d[g]) - 33'(thr);
                end else begin
                    acc[g] = acc[g] + 33'(d[g]);
                end
            end
        end
        @(posedge hclk);
        energy_valid <= 3'b000;
        // Spacing keeps 100 increments longer than one pulse
        repeat (2) @(posedge hclk);
    endtask

    task automatic clear_model();
        for (int g = 0; g < 3; g++) begin
            acc[g] = '0;
            cnt[g] = '0;
            pulses[g] = 0;
        end
    endtask

    task automatic check_counts();
        for (int g = 0; g < 3; g++) begin
            rchk(IDX_ENERGY0 + 8'(g), {16'h0, cnt[g]});
            check(32'(pulses[g]), 32'(cnt[g] / 100));
        end
    endtask

    task automatic results();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog, about nine times the expected run
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge hclk);
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = '0;
        energy_valid = '0;
        energy_delta = '0;
        num_errors = 0;
        samples_checked = 0;
        seed = 32'h22d70469;
        thr = '0;
        model_run = 1'b0;
        clear_model();
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(IDX_START, 32'h6886);
        rchk(IDX_THR_HI, 32'h0861);
        rchk(IDX_THR_LO, 32'hc468);
        rchk(8'h40, 32'h0);
        flags(1'b0);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            w = rnd();
            wr(IDX_THR_HI, v);
            wr(IDX_THR_LO, w);
            rchk(IDX_THR_HI, {16'h0, v[15:0]});
            rchk(IDX_THR_LO, {16'h0, w[15:0]});
        end
        sum = 16'(v[15:0] + w[15:0]);
        // Low bits 11 match none of the three codes
        bad = 16'(rnd()) | 16'h0003;
        wr(IDX_START, {16'h0, bad});
        rchk(IDX_START, {16'h0, bad});
        flags(1'b1);
        rchk(IDX_STATUS, 32'hf);
        repeat (20) begin
            for (int g = 0; g < 3; g++) dd[g] = 16'(rnd());
            sample(3'b111, dd);
        end
        check_counts();
        wr(IDX_CHK_EXP, {16'h0, sum ^ 16'h0001});
        wr(IDX_START, 32'h8765);
        flags(1'b1);
        rchk(IDX_STATUS, 32'hb);
        wr(IDX_CHK_EXP, {16'h0, sum});
        flags(1'b0);
        rchk(IDX_STATUS, 32'h8);
        wr(IDX_CHK_EXP, {16'h0, sum ^ 16'h0001});
        wr(IDX_START, 32'h6886);
        flags(1'b0);
        wr(IDX_START, 32'h5678);
        flags(1'b0);
        rchk(IDX_THR_HI, 32'h0861);
        rchk(IDX_THR_LO, 32'hc468);
        rchk(IDX_CHK_EXP, 32'h0);
        rchk(IDX_STATUS, 32'h4);
        // High word must take part in the compare
        wr(IDX_THR_HI, 32'h1);
        wr(IDX_THR_LO, 32'h0);
        thr = 32'h0001_0000;
        model_run = 1'b1;
        sample(3'b001, {16'h0, 16'h0, 16'hffff});
        sample(3'b001, {16'h0, 16'h0, 16'h0002});
        check_counts();
        // Random run with a small threshold, multiple of four
        wr(IDX_START, 32'h5678);
        clear_model();
        thr = 32'(rnd() % 8) * 4 + 8;
        wr(IDX_THR_HI, 32'h0);
        wr(IDX_THR_LO, thr);
        repeat (900) begin
            for (int g = 0; g < 3; g++) dd[g] = 16'((rnd() % thr) + 1);
            sample(3'(rnd()), dd);
        end
        repeat (300) @(posedge hclk);
        check_counts();
        flags(1'b0);
        results();
    end
endmodule
